// ### logic/tmpc_regs.vh
// Purpose: Register map, field positions and timing counts for the touch
//          mode and power control block
// Assumes: 100 MHz mclk
// Notes:   Included by every design file of the block
`ifndef TMPC_REGS_VH
`define TMPC_REGS_VH

// Register offsets on the serial bus
`define TMPC_ADDR_TICK      8'h0e
`define TMPC_ADDR_CFG       8'h13

// Power-up values
`define TMPC_TICK_RST       8'h05
`define TMPC_CFG_RST        8'h14

// Tick period code limit, base offset and fixed period
`define TMPC_TICK_MAX       8'h1a
`define TMPC_TICK_BASE_MS   6'd5
`define TMPC_FIXED_TICK_MS  6'd8

// Configuration field positions
`define TMPC_CFG_SCAN       0
`define TMPC_CFG_IRQ_OUTPUT_ENABLE      1
`define TMPC_CFG_DCN        2
`define TMPC_CFG_RSTN       4
`define TMPC_CFG_IRQ_SPACING_FACTOR_LO    5
`define TMPC_CFG_IRQ_SPACING_FACTOR_HI    7

// Time base
`define TMPC_CLK_NS         10
`define TMPC_NS_PER_MS      1000000
`define TMPC_CYC_PER_MS     (`TMPC_NS_PER_MS / `TMPC_CLK_NS)

// Low-power scan scaling
`define TMPC_DEBOUNCE       24'd4
`define TMPC_IDLE_SCALE     24'd64

// Bus slave address (arbitrary value)
`define TMPC_SLAVE_ADDR     7'h2a

`endif

// ### logic/tmpc_pin_sync.v
// Purpose: Three-stage synchroniser with agreement filter and edge pulses
// Assumes: Pin idles high
// Notes:   Level changes only once stages two and three agree
`include "tmpc_regs.vh"

module tmpc_pin_sync (
  input  wire mclk,
  input  wire sys_rst,
  input  wire pin,
  output reg  level,
  output reg  fall,
  output reg  rise
);

  reg s1;
  reg s2;
  reg s3;

  always @(posedge mclk) begin
    if (sys_rst) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
      fall  <= 1'b0;
      rise  <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      fall <= 1'b0;
      rise <= 1'b0;
      if (s2 == s3) begin
        level <= s3;
        fall  <= level & ~s3;
        rise  <= ~level & s3;
      end
    end
  end

endmodule

// ### logic/tmpc_tick_gen.v
// Purpose: Master tick generator, one pulse every period_ms milliseconds
// Assumes: period_ms is at least 1
// Notes:   CYC_PER_MS may be shortened for simulation
`include "tmpc_regs.vh"

module tmpc_tick_gen #(
  parameter CYC_PER_MS = `TMPC_CYC_PER_MS,
  parameter CW         = 17
) (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire [5:0] period_ms,
  output reg        tick
);

  localparam [31:0]   LAST_W = CYC_PER_MS - 1;
  localparam [CW-1:0] LAST   = LAST_W[CW-1:0];

  reg [CW-1:0] cyc_cnt;
  reg [5:0]    ms_cnt;

  always @(posedge mclk) begin
    if (sys_rst) begin
      cyc_cnt <= {CW{1'b0}};
      ms_cnt  <= 6'h00;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (cyc_cnt >= LAST) begin
        cyc_cnt <= {CW{1'b0}};
        if (ms_cnt + 6'h01 >= period_ms) begin
          ms_cnt <= 6'h00;
          tick   <= 1'b1;
        end else begin
          ms_cnt <= ms_cnt + 6'h01;
        end
      end else begin
        cyc_cnt <= cyc_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ### logic/tmpc_core.v
// Purpose: Operating mode, master tick, interrupt spacing and low-power
//          scan scheduling, reached over a serial two-wire bus slave
// Assumes: scl/sda/wake_pin are asynchronous pins; other inputs on mclk
// Notes:   Registers other than tick and config live outside, via ext_*
//
// Function
// - All timing from master tick; 8 ms outside continuous
// - Tick code N gives N+5 ms
// - Out-of-range tick code forced to 26
// - Duty-cycled run scans, sleeps between scans
// - Idle stop: no scan, all writes accepted
// - Off stop: no scan, no bus response
// - Wake pin falling edge sets duty-cycle disable
// - Wake edge only exit from off stop; duty-cycled run also exits on config write
// - Config bit 2 active-low duty-cycle control
// - Config bit 0 enables scanning, run mode
// - Config bit 4 low resets all but the bus slave
// - Config bit 1 enables interrupt output
// - Bits 7:5 space interrupts by code+1 ticks
// - Low-power scheduling only in duty-cycled run
// - Normal period ((code+5)/8+1)*mult*4 ticks
// - Slow period is normal times sleep factor
// - Idle timeout is ((code+5)/8+1)*factor*mult*64 ticks
// - Idle goes slow, touch returns to normal
// - Run modes accept only config writes
// - Zero idle or sleep factor disables slow
`include "tmpc_regs.vh"

module tmpc_core #(
  parameter       CYC_PER_MS = `TMPC_CYC_PER_MS,
  parameter [6:0] SLAVE_ADDR = `TMPC_SLAVE_ADDR
) (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe_n,
  input  wire       wake_pin,
  input  wire [7:0] sample_period_multiplier,
  input  wire [2:0] idle_timeout_factor,
  input  wire [4:0] sleep_duration_factor,
  input  wire       touch_detected,
  input  wire       irq_event,
  input  wire       irq_ack,
  input  wire [7:0] ext_rd_data,
  output reg  [7:0] ext_addr,
  output reg  [7:0] ext_wr_data,
  output reg        ext_wr_en,
  output reg        ctrl_rst,
  output reg  [3:0] mode_state,
  output wire       master_tick,
  output reg        scan_pulse,
  output reg        low_power_sleep,
  output reg        slow_scan,
  output reg        irq_n
);

  localparam [3:0] MODE_CONTINUOUS_RUN_MODE = 4'h1;
  localparam [3:0] MODE_DUTY_CYCLED_RUN_MODE = 4'h2;
  localparam [3:0] MODE_IDLE = 4'h4;
  localparam [3:0] MODE_OFF  = 4'h8;

  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_AACK  = 7'h04;
  localparam [6:0] ST_WRITE = 7'h08;
  localparam [6:0] ST_WACK  = 7'h10;
  localparam [6:0] ST_READ  = 7'h20;
  localparam [6:0] ST_RACK  = 7'h40;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire scl_lvl;
  wire scl_fall;
  wire scl_rise;
  wire sda_lvl;
  wire sda_fall;
  wire sda_rise;
  wire wake_fall;

  tmpc_pin_sync u_scl (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin     (scl_in),
    .level   (scl_lvl),
    .fall    (scl_fall),
    .rise    (scl_rise)
  );

  tmpc_pin_sync u_sda (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin     (sda_in),
    .level   (sda_lvl),
    .fall    (sda_fall),
    .rise    (sda_rise)
  );

  tmpc_pin_sync u_wake (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin     (wake_pin),
    .level   (),
    .fall    (wake_fall),
    .rise    ()
  );

  //////////////////////////////////////////////////////////////////////////
  // Registers and mode decode

  reg  [7:0] tick_period;
  reg  [7:0] mode_config;
  reg        soft_rst;
  wire       rst_all = sys_rst | soft_rst;

  wire       scan_enable          = mode_config[`TMPC_CFG_SCAN];
  wire       irq_output_enable    = mode_config[`TMPC_CFG_IRQ_OUTPUT_ENABLE];
  wire       duty_cycle_disable_n = mode_config[`TMPC_CFG_DCN];
  wire [2:0] irq_spacing_factor   =
             mode_config[`TMPC_CFG_IRQ_SPACING_FACTOR_HI:`TMPC_CFG_IRQ_SPACING_FACTOR_LO];

  reg  [3:0] next_mode;
  always @* begin
    case ({scan_enable, duty_cycle_disable_n})
      2'b11:   next_mode = MODE_CONTINUOUS_RUN_MODE;
      2'b10:   next_mode = MODE_DUTY_CYCLED_RUN_MODE;
      2'b01:   next_mode = MODE_IDLE;
      default: next_mode = MODE_OFF;
    endcase
  end

  wire continuous_run_mode  = (mode_state == MODE_CONTINUOUS_RUN_MODE);
  wire duty_cycled_run_mode = (mode_state == MODE_DUTY_CYCLED_RUN_MODE);
  wire idle_stop_mode       = (mode_state == MODE_IDLE);
  wire off_stop_mode        = (mode_state == MODE_OFF);

  // Bus is dead in off stop and asleep in duty-cycled run
  wire bus_ok = ~off_stop_mode & ~low_power_sleep;

  //////////////////////////////////////////////////////////////////////////
  // Master tick

  wire [5:0] tick_period_code = tick_period[5:0];
  wire [5:0] period_ms = continuous_run_mode ?
             tick_period_code + `TMPC_TICK_BASE_MS :
             `TMPC_FIXED_TICK_MS;

  tmpc_tick_gen #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .mclk      (mclk),
    .sys_rst   (rst_all),
    .period_ms (period_ms),
    .tick      (master_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Low-power scan scheduling

  wire [8:0]  code_sum  = {1'b0, tick_period} + 9'h005;
  wire [23:0] mult24    = {18'h00000, code_sum[8:3] + 6'h01};
  wire [23:0] tasp24    = {16'h0000, sample_period_multiplier};
  wire [23:0] max_response_time = mult24 * tasp24 * `TMPC_DEBOUNCE;
  wire [23:0] slow_ticks =
              max_response_time * {19'h00000, sleep_duration_factor};
  wire [23:0] idle_timeout = mult24 * tasp24 *
              {21'h000000, idle_timeout_factor} * `TMPC_IDLE_SCALE;
  wire        lp_enable = (idle_timeout_factor != 3'h0) &
                          (sleep_duration_factor != 5'h00);
  wire [23:0] scan_period = slow_scan ? slow_ticks : max_response_time;

  reg [23:0] scan_cnt;
  reg [23:0] idle_cnt;

  always @(posedge mclk) begin
    if (rst_all) begin
      scan_cnt        <= 24'h000000;
      idle_cnt        <= 24'h000000;
      slow_scan       <= 1'b0;
      scan_pulse      <= 1'b0;
      low_power_sleep <= 1'b0;
    end else begin
      scan_pulse <= 1'b0;
      if (!duty_cycled_run_mode) begin
        scan_cnt        <= 24'h000000;
        idle_cnt        <= 24'h000000;
        slow_scan       <= 1'b0;
        low_power_sleep <= 1'b0;
        scan_pulse      <= continuous_run_mode & master_tick;
      end else begin
        if (touch_detected) begin
          slow_scan <= 1'b0;
          idle_cnt  <= 24'h000000;
        end else if (master_tick && !slow_scan) begin
          if (lp_enable && idle_cnt + 24'h000001 >= idle_timeout) begin
            slow_scan <= 1'b1;
            idle_cnt  <= 24'h000000;
          end else begin
            idle_cnt <= idle_cnt + 24'h000001;
          end
        end
        if (master_tick) begin
          if (scan_cnt + 24'h000001 >= scan_period) begin
            scan_cnt        <= 24'h000000;
            scan_pulse      <= 1'b1;
            low_power_sleep <= 1'b0;
          end else begin
            scan_cnt        <= scan_cnt + 24'h000001;
            low_power_sleep <= 1'b1;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt spacing

  reg       irq_pending;
  reg [3:0] hold_cnt;

  always @(posedge mclk) begin
    if (rst_all) begin
      irq_pending <= 1'b0;
      hold_cnt    <= 4'h0;
      irq_n       <= 1'b1;
    end else begin
      if (irq_event)
        irq_pending <= 1'b1;
      else if (irq_ack)
        irq_pending <= 1'b0;
      if (master_tick && hold_cnt != 4'h0)
        hold_cnt <= hold_cnt - 4'h1;
      if (!irq_n) begin
        if (!irq_pending || !irq_output_enable)
          irq_n <= 1'b1;
      end else if (irq_pending && irq_output_enable &&
                   hold_cnt == 4'h0) begin
        irq_n    <= 1'b0;
        hold_cnt <= {1'b0, irq_spacing_factor} + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave

  reg  [6:0] bus_state;
  reg  [7:0] shreg;
  reg  [3:0] bitcnt;
  reg        rw_read;
  reg        first_byte;
  reg        wr_commit;
  reg  [7:0] wr_byte;
  reg  [7:0] rd_data;

  assign sda_out = 1'b0;

  always @* begin
    case (ext_addr)
      `TMPC_ADDR_TICK: rd_data = tick_period;
      `TMPC_ADDR_CFG:  rd_data = mode_config;
      default:         rd_data = ext_rd_data;
    endcase
  end

  wire start_cond = sda_fall & scl_lvl;
  wire stop_cond  = sda_rise & scl_lvl;

  always @(posedge mclk) begin
    if (sys_rst) begin
      bus_state  <= ST_IDLE;
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      rw_read    <= 1'b0;
      first_byte <= 1'b0;
      wr_commit  <= 1'b0;
      wr_byte    <= 8'h00;
      ext_addr   <= 8'h00;
      sda_oe_n   <= 1'b1;
    end else begin
      wr_commit <= 1'b0;
      if (start_cond) begin
        sda_oe_n <= 1'b1;
        bitcnt   <= 4'h0;
        bus_state <= bus_ok ? ST_ADDR : ST_IDLE;
      end else if (stop_cond) begin
        sda_oe_n  <= 1'b1;
        bus_state <= ST_IDLE;
      end else begin
        case (bus_state)
          ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_lvl};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                rw_read    <= shreg[0];
                first_byte <= ~shreg[0];
                sda_oe_n   <= 1'b0;
                bus_state  <= ST_AACK;
              end else begin
                bus_state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rw_read) begin
                shreg     <= rd_data;
                sda_oe_n  <= rd_data[7];
                bitcnt    <= 4'h1;
                ext_addr  <= ext_addr + 8'h01;
                bus_state <= ST_READ;
              end else begin
                sda_oe_n  <= 1'b1;
                bus_state <= ST_WRITE;
              end
            end
          end
          ST_WRITE: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_lvl};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              sda_oe_n  <= 1'b0;
              bus_state <= ST_WACK;
              if (first_byte) begin
                ext_addr   <= shreg;
                first_byte <= 1'b0;
                bitcnt     <= 4'h0;
              end else begin
                wr_byte   <= shreg;
                wr_commit <= 1'b1;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8)
                ext_addr <= ext_addr + 8'h01;
              sda_oe_n  <= 1'b1;
              bitcnt    <= 4'h0;
              bus_state <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe_n  <= 1'b1;
                bus_state <= ST_RACK;
              end else begin
                shreg    <= {shreg[6:0], 1'b1};
                sda_oe_n <= shreg[6];
                bitcnt   <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise && sda_lvl) begin
              bus_state <= ST_IDLE;
            end else if (scl_fall) begin
              shreg     <= rd_data;
              sda_oe_n  <= rd_data[7];
              bitcnt    <= 4'h1;
              ext_addr  <= ext_addr + 8'h01;
              bus_state <= ST_READ;
            end
          end
          default: begin
            sda_oe_n  <= 1'b1;
            bus_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes, wake edge and soft reset

  wire wr_cfg   = wr_commit && ext_addr == `TMPC_ADDR_CFG;
  wire wr_tick  = wr_commit && ext_addr == `TMPC_ADDR_TICK;

  always @(posedge mclk) begin
    if (rst_all) begin
      tick_period <= `TMPC_TICK_RST;
      mode_config <= `TMPC_CFG_RST;
      mode_state  <= MODE_IDLE;
      ext_wr_en   <= 1'b0;
      ext_wr_data <= 8'h00;
    end else begin
      mode_state <= next_mode;
      ext_wr_en  <= 1'b0;
      if (wr_cfg)
        mode_config <= wr_byte;
      if (wake_fall)
        mode_config[`TMPC_CFG_DCN] <= 1'b1;
      if (wr_tick && idle_stop_mode) begin
        if (wr_byte > `TMPC_TICK_MAX)
          tick_period <= `TMPC_TICK_MAX;
        else
          tick_period <= wr_byte;
      end
      if (wr_commit && !wr_cfg && !wr_tick && idle_stop_mode) begin
        ext_wr_en   <= 1'b1;
        ext_wr_data <= wr_byte;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      soft_rst <= 1'b0;
      ctrl_rst <= 1'b1;
    end else begin
      soft_rst <= wr_cfg & ~wr_byte[`TMPC_CFG_RSTN];
      ctrl_rst <= wr_cfg & ~wr_byte[`TMPC_CFG_RSTN];
    end
  end

endmodule

// ### tb/tmpc_core_props.sv
// Purpose: Port-level checks of mode, tick, scan and interrupt timing
// Assumes: CYC_PER_MS matches the bound instance
// Notes:   Bound to every tmpc_core instance
module tmpc_core_props #(
  parameter int CYC_PER_MS = 100000
) (
  input logic       mclk,
  input logic       sys_rst,
  input logic       sda_oe_n,
  input logic       touch_detected,
  input logic       ext_wr_en,
  input logic       ctrl_rst,
  input logic [3:0] mode_state,
  input logic       master_tick,
  input logic       scan_pulse,
  input logic       low_power_sleep,
  input logic       slow_scan,
  input logic       irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FIX_CYC = 8 * CYC_PER_MS;
  int unsigned cnt;
  logic [3:0]  pm;
  logic [3:0]  pm2;
  logic        valid;
  logic        seen;
  logic        pi;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Tick interval length, and whether it ran wholly in one fixed-rate mode
  always @(posedge mclk) begin
    pm <= mode_state;
    pm2 <= pm;
    cnt <= (sys_rst || master_tick) ? 1 : cnt + 1;
    if (sys_rst || ctrl_rst || mode_state[0] || mode_state != pm || pm != pm2)
      valid <= 1'b0;
    else if (master_tick)
      valid <= 1'b1;
    pi <= irq_n;
    if (sys_rst || ctrl_rst)
      seen <= 1'b1;
    else if (pi && !irq_n)
      seen <= master_tick;
    else
      seen <= seen | master_tick;
  end
  wr_idle_only_a: assert property (ext_wr_en |-> mode_state[2])
    else $error("outside write while not in idle stop");
  stop_no_scan_a: assert property (
    $past(mode_state[3:2], 2) != 2'b00 && mode_state[3:2] != 2'b00
    |-> !scan_pulse) else $error("scan pulse in a stop mode");
  sleep_in_duty_a: assert property (low_power_sleep |-> mode_state[1] ||
    $past(mode_state[1]) || $past(mode_state[1], 2))
    else $error("low power sleep outside duty-cycled run");
  touch_ends_slow_a: assert property (
    touch_detected && slow_scan && mode_state[1] |-> ##[1:2] !slow_scan)
    else $error("touch did not restore the normal scan period");
  fixed_tick_a: assert property (master_tick && valid |-> cnt == FIX_CYC)
    else $error("master tick period wrong outside continuous run");
  irq_spacing_a: assert property ($fell(irq_n) |-> seen)
    else $error("interrupts closer than one master tick");
  soft_reset_a: assert property (
    ctrl_rst |-> ##[1:3] (mode_state == 4'h4 && irq_n))
    else $error("soft reset did not return to idle stop");
  off_no_ack_a: assert property ($fell(sda_oe_n) |-> !mode_state[3])
    else $error("bus answered in off stop mode");
endmodule

bind tmpc_core tmpc_core_props #(.CYC_PER_MS(CYC_PER_MS))
  i_tmpc_core_props (
  .mclk, .sys_rst, .sda_oe_n, .touch_detected, .ext_wr_en, .ctrl_rst,
  .mode_state, .master_tick, .scan_pulse, .low_power_sleep, .slow_scan,
  .irq_n
);

// ### tb/tmpc_host.sv
// Purpose: Host model, two-wire bus master and wake pin
// Assumes: Data line resolved and pulled up by the bench
// Notes:   Each bus clock level lasts 10 mclk
module tmpc_host (
  input  logic mclk,
  input  logic sda_line,
  output logic scl,
  output logic sda_drv,
  output logic wake_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    wake_pin = 1'b1;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Drive one bit while the clock is low, sample it while high
  task automatic bit_io(input logic b, output logic r);
    cyc(4);
    sda_drv <= b;
    cyc(6);
    scl <= 1'b1;
    cyc(5);
    r = sda_line;
    cyc(5);
    scl <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ab,
                         output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, r);
    ack = ~r;
  endtask
  task automatic start;
    cyc(2);
    sda_drv <= 1'b0;
    cyc(10);
    scl <= 1'b0;
  endtask
  task automatic stop;
    cyc(4);
    sda_drv <= 1'b0;
    cyc(6);
    scl <= 1'b1;
    cyc(10);
    sda_drv <= 1'b1;
    cyc(10);
  endtask
  // Pointer write, then one data byte or a separate one-byte read
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] d, input logic rd,
                      output logic [7:0] q, output logic ok);
    logic a0, a1, a2, nk;
    start;
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ptr, 1'b1, q, a1);
    if (!rd) byte_io(d, 1'b1, q, a2);
    stop;
    if (rd) begin
      start;
      byte_io({dev, 1'b1}, 1'b1, q, a2);
      byte_io(8'hff, 1'b1, q, nk);
      stop;
    end
    ok = a0 & a1 & a2;
  endtask
  task automatic wake;
    wake_pin <= 1'b0;
    cyc(10);
    wake_pin <= 1'b1;
    cyc(10);
  endtask
endmodule

// ### tb/tmpc_core_tb.sv
// Purpose: Register, mode, tick, interrupt and low-power scan tests
// Assumes: Millisecond shortened to 10 mclk
// Notes:   Outside registers answer with the inverted pointer
module tmpc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         CYC = 10;
  localparam logic [6:0] SADR = 7'h2a;
  logic        mclk, sys_rst, scl, sda_drv, wake_pin, sda_out, sda_oe_n;
  logic        ext_wr_en, ctrl_rst, master_tick, scan_pulse, ok;
  logic        low_power_sleep, slow_scan, irq_n;
  logic [2:0]  ev, itf;
  logic [3:0]  mode_state;
  logic [4:0]  sdf;
  logic [7:0]  spm, ext_addr, ext_wr_data, ew_a, ew_d, q;
  logic [15:0] tv [4] = '{16'h0000, 16'h1a1a, 16'h1b1a, 16'hff1a};
  int          n, checks, err_total;
  wire         sda_line = sda_drv & (sda_oe_n | sda_out);

  tmpc_core #(.CYC_PER_MS(CYC), .SLAVE_ADDR(SADR)) i_tmpc_core (
    .mclk, .sys_rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n,
    .wake_pin, .sample_period_multiplier(spm), .idle_timeout_factor(itf),
    .sleep_duration_factor(sdf), .touch_detected(ev[2]),
    .irq_event(ev[1]), .irq_ack(ev[0]), .ext_rd_data(~ext_addr),
    .ext_addr, .ext_wr_data, .ext_wr_en, .ctrl_rst, .mode_state,
    .master_tick, .scan_pulse, .low_power_sleep, .slow_scan, .irq_n
  );
  tmpc_host i_tmpc_host (.mclk, .sda_line, .scl, .sda_drv, .wake_pin);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (ext_wr_en === 1'b1) begin
    ew_a <= ext_addr;
    ew_d <= ext_wr_data;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_tmpc_host.xfer(SADR, a, d, 1'b0, q, ok);
    chk("write ack", 8'h01, 8'(ok));
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_tmpc_host.xfer(SADR, a, 8'h00, 1'b1, q, ok);
    chk("read ack", 8'h01, 8'(ok));
    chk("read data", e, q);
  endtask
  // Wait for tick, slow scan, interrupt or scan start, bounded
  task automatic await(input int w, lim);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (n < lim && !(w == 0 ? master_tick === 1'b1 :
               w == 1 ? slow_scan === 1'b1 : w == 2 ? irq_n === 1'b0 :
               scan_pulse === 1'b1));
    if (n >= lim) begin
      $display("Error wait %0d expected event seen timeout", w);
      err_total++;
      print_verdict();
    end
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 3'b000;
  endtask
  task automatic mode(input logic [7:0] e);
    i_tmpc_host.cyc(4);
    chk("mode", e, 8'(mode_state));
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    ev = 3'b000;
    spm = 8'h01;
    itf = 3'h0;
    sdf = 5'h02;
    ew_a = 8'h00;
    ew_d = 8'h00;
    checks = 0;
    err_total = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    mode(8'h04);
    rd(8'h0e, 8'h05);
    rd(8'h13, 8'h14);
    foreach (tv[i]) begin
      wr(8'h0e, tv[i][15:8]);
      rd(8'h0e, tv[i][7:0]);
    end
    await(0, 1000);
    await(0, 1000);
    chk("idle tick", 8'(8 * CYC), 8'(n));
    wr(8'h11, 8'h5a);
    chk("ext write", 8'h11, ew_a);
    chk("ext data", 8'h5a, ew_d);
    rd(8'h11, 8'hee);
    i_tmpc_host.xfer(7'h2b, 8'h13, 8'h00, 1'b1, q, ok);
    chk("foreign address ack", 8'h00, 8'(ok));
    wr(8'h0e, 8'h00);
    wr(8'h13, 8'h37);
    mode(8'h01);
    await(0, 1000);
    await(0, 1000);
    chk("run tick", 8'(5 * CYC), 8'(n));
    wr(8'h0e, 8'h0a);
    rd(8'h0e, 8'h00);
    wr(8'h11, 8'h33);
    chk("run ext data", 8'h5a, ew_d);
    pulse(3'b010);
    i_tmpc_host.cyc(3);
    chk("irq set", 8'h00, 8'(irq_n));
    pulse(3'b001);
    i_tmpc_host.cyc(3);
    chk("irq clear", 8'h01, 8'(irq_n));
    pulse(3'b010);
    i_tmpc_host.cyc(3);
    chk("irq held off", 8'h01, 8'(irq_n));
    await(2, 300);
    chk("irq spacing", 8'h01, 8'(n > 30));
    wr(8'h13, 8'h35);
    i_tmpc_host.cyc(4);
    chk("irq disabled", 8'h01, 8'(irq_n));
    wr(8'h13, 8'h07);
    mode(8'h04);
    rd(8'h0e, 8'h05);
    rd(8'h13, 8'h14);
    wr(8'h13, 8'h33);
    mode(8'h02);
    i_tmpc_host.cyc(11000);
    chk("slow with zero factor", 8'h00, 8'(slow_scan));
    itf <= 3'h1;
    sdf <= 5'h03;
    await(1, 12000);
    await(3, 2500);
    await(3, 2500);
    chk("slow period", 8'h18, 8'(n / (8 * CYC)));
    pulse(3'b100);
    i_tmpc_host.cyc(3);
    chk("touch ends slow", 8'h00, 8'(slow_scan));
    await(3, 2000);
    await(3, 2000);
    chk("normal period", 8'h08, 8'(n / (8 * CYC)));
    spm <= 8'h02;
    await(3, 2000);
    await(3, 2000);
    chk("scaled period", 8'h10, 8'(n / (8 * CYC)));
    i_tmpc_host.wake();
    mode(8'h01);
    rd(8'h13, 8'h37);
    wr(8'h13, 8'h10);
    mode(8'h08);
    i_tmpc_host.xfer(SADR, 8'h13, 8'h00, 1'b1, q, ok);
    chk("off ack", 8'h00, 8'(ok));
    i_tmpc_host.wake();
    mode(8'h04);
    rd(8'h13, 8'h14);
    print_verdict();
  end
endmodule
